// ===== timer_rtc16.sv
// What this block does
// - divide pin clock to 1 Hz tick
// - enable starts rtc count from one
// - rtc match rolls count over to zero
// - rtc match sets raw, masked, interrupt
// - rtc stall permit keeps rtc running
// - configuration four selects split 16-bit timers
// - 16-bit down-counter with 8-bit prescaler
// - reload after zero, one-shot clears enable
// - time-out flag held until cleared
// - trigger pulse on time-out when enabled
// - interval load write reloads next cycle
// - stall bit freezes the timer count
// - prescaler only in one-shot and periodic
// - edge count down-counter, edge type selectable
// - count match flags, reloads, stops timer
// - edge time free-runs from load value
// - edge time captures count and flags
// - edge time keeps running, reloads at zero
// - pwm mode decode, no status flags
// - pwm high at load, low at match
`timescale 1ns/1ns
`default_nettype none
module timer_rtc16 #(
   parameter int RTC_DIV = timer_pkg::RTC_DIV
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic        timer_irq,
   output var  logic        trigger_a,
   output var  logic        trigger_b,
   input  wire logic        capture_pin_zero_in,
   output var  logic        capture_pin_zero_out,
   output var  logic        capture_pin_zero_oe,
   input  wire logic        capture_pin_one_in,
   output var  logic        capture_pin_one_out,
   output var  logic        capture_pin_one_oe
);
   logic [2:0]  configuration_reg_q;
   logic [3:0]  timer_mode_reg_q [2];
   logic [15:0] timer_control_reg_q;
   logic [15:0] interrupt_mask_reg_q;
   logic [15:0] raw_status_reg_q;
   logic [15:0] interval_load_q [2];
   logic [15:0] match_reg_q [2];
   logic [7:0]  prescale_reg_q [2];
   logic [15:0] cnt_q [2];
   logic [7:0]  pcnt_q [2];
   logic [15:0] cap_q [2];
   logic [1:0]  pwm_q;
   logic [1:0]  pwm_oe_q;
   logic [1:0]  trig_q;
   logic [31:0] rtc_q;
   logic [15:0] rtc_div_q;
   logic        irq_q;
   logic [31:0] rdata_q;
   logic        ph_wr_q;
   logic [11:0] ph_addr_q;
   logic [1:0]  sync1_q;
   logic [1:0]  sync2_q;
   logic [1:0]  sync3_q;
   logic [1:0]  stable_q;

   logic                      split;
   logic                      rtc_mode;
   logic                      wr_ctl;
   logic                      wr_icr;
   logic [1:0]                wr_ilr;
   logic [1:0]                rise;
   logic [1:0]                fall;
   logic [1:0]                en;
   logic [1:0]                run;
   logic [1:0]                edge_ok;
   logic [1:0]                timeout;
   logic [1:0]                cm_hit;
   logic [1:0]                cap_hit;
   logic [15:0]               set_bits;
   logic [15:0]               ris_d;
   logic                      rtc_run;
   logic                      rtc_tick;
   logic                      rtc_hit;
   logic [31:0]               rtc_match;
   timer_pkg::timer_mode_type tmode [2];

   assign split     = configuration_reg_q == timer_pkg::CFG_SPLIT;
   assign rtc_mode  = configuration_reg_q == timer_pkg::CFG_RTC;
   assign wr_ctl    = ph_wr_q && ph_addr_q == timer_pkg::OFF_CTL;
   assign wr_icr    = ph_wr_q && ph_addr_q == timer_pkg::OFF_ICR;
   assign wr_ilr[0] = ph_wr_q && ph_addr_q == timer_pkg::OFF_AILR;
   assign wr_ilr[1] = ph_wr_q && ph_addr_q == timer_pkg::OFF_BILR;
   assign rtc_match = {match_reg_q[1], match_reg_q[0]};

   // bus address phase, words only, always zero wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_q   <= 1'b0;
         ph_addr_q <= 12'h000;
      end else if (hready) begin
         ph_wr_q   <= hsel && htrans[1] && hwrite && hsize == 3'h2;
         ph_addr_q <= haddr[11:0];
      end
   end

   // constant bus answer, always ready and okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // three flop pin synchroniser, change taken when stages 2 and 3 agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q  <= 2'h0;
         sync2_q  <= 2'h0;
         sync3_q  <= 2'h0;
         stable_q <= 2'h0;
      end else begin
         sync1_q <= {capture_pin_one_in, capture_pin_zero_in};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int n = 0; n < 2; n++) begin
            if (sync2_q[n] == sync3_q[n])
               stable_q[n] <= sync3_q[n];
         end
      end
   end

   // per-timer decode and events
   always_comb begin
      for (int n = 0; n < 2; n++) begin
         logic [1:0] sel;
         sel = timer_control_reg_q[n*timer_pkg::CTL_B_SHIFT+timer_pkg::CTL_EVT
                                   +: 2];
         rise[n] = sync2_q[n] == sync3_q[n] && sync3_q[n] && !stable_q[n];
         fall[n] = sync2_q[n] == sync3_q[n] && !sync3_q[n] && stable_q[n];
         tmode[n] = timer_pkg::decode_mode(timer_mode_reg_q[n]);
         en[n] = timer_control_reg_q[n*timer_pkg::CTL_B_SHIFT
                                     + timer_pkg::CTL_EN];
         run[n] = split && en[n] && !timer_control_reg_q[
                  n*timer_pkg::CTL_B_SHIFT+timer_pkg::CTL_STALL];
         edge_ok[n] = 1'b0;
         if (tmode[n] == timer_pkg::TM_EDGE_COUNT) begin
            unique case (sel)
               timer_pkg::EVT_RISE: edge_ok[n] = rise[n];
               timer_pkg::EVT_FALL: edge_ok[n] = fall[n];
               timer_pkg::EVT_BOTH: edge_ok[n] = rise[n] | fall[n];
               default: edge_ok[n] = 1'b0;
            endcase
         end else begin
            // edge time takes one polarity only
            edge_ok[n] = (sel == timer_pkg::EVT_FALL) ? fall[n] : rise[n];
         end
         timeout[n] = run[n] && cnt_q[n] == 16'h0000 && pcnt_q[n] == 8'h00 &&
                      (tmode[n] == timer_pkg::TM_ONESHOT ||
                       tmode[n] == timer_pkg::TM_PERIODIC);
         cm_hit[n] = run[n] && tmode[n] == timer_pkg::TM_EDGE_COUNT &&
                     edge_ok[n] &&
                     timer_pkg::dec16(cnt_q[n]) == match_reg_q[n];
         cap_hit[n] = run[n] && tmode[n] == timer_pkg::TM_EDGE_TIME &&
                      edge_ok[n];
      end
   end

   // rtc runs on the even pin clock unless stalled without stall permit
   assign rtc_run = rtc_mode && en[0] &&
      (timer_control_reg_q[timer_pkg::CTL_RTC_STALL_PERMIT] ||
       !(timer_control_reg_q[timer_pkg::CTL_STALL] ||
         timer_control_reg_q[timer_pkg::CTL_B_SHIFT+timer_pkg::CTL_STALL]));
   assign rtc_tick = rtc_run && rise[0] &&
                     rtc_div_q == 16'(RTC_DIV - 1);
   assign rtc_hit  = rtc_tick && rtc_q == rtc_match;

   // divider from the 32.768 KHz pin to the 1 Hz tick
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         rtc_div_q <= 16'h0000;
      else if (!rtc_run)
         rtc_div_q <= 16'h0000;
      else if (rise[0])
         rtc_div_q <= rtc_tick ? 16'h0000 : 16'(rtc_div_q + 16'h0001);
   end

   // 32-bit rtc up-counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         rtc_q <= timer_pkg::RTC_START;
      else if (wr_ctl && rtc_mode && hwdata[timer_pkg::CTL_EN] && !en[0])
         rtc_q <= timer_pkg::RTC_START;
      else if (rtc_hit)
         rtc_q <= timer_pkg::RTC_ROLL;
      else if (rtc_tick)
         rtc_q <= rtc_q + 32'h00000001;
   end

   // configuration, mode, mask, load, match and prescale registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         configuration_reg_q  <= 3'h0;
         interrupt_mask_reg_q <= 16'h0000;
         for (int n = 0; n < 2; n++) begin
            timer_mode_reg_q[n] <= 4'h0;
            interval_load_q[n]  <= timer_pkg::CNT_RST;
            match_reg_q[n]      <= timer_pkg::CNT_RST;
            prescale_reg_q[n]   <= timer_pkg::PRE_RST;
         end
      end else if (ph_wr_q) begin
         unique case (ph_addr_q)
            timer_pkg::OFF_CFG:   configuration_reg_q  <= hwdata[2:0];
            timer_pkg::OFF_AMODE: timer_mode_reg_q[0]  <= hwdata[3:0];
            timer_pkg::OFF_BMODE: timer_mode_reg_q[1]  <= hwdata[3:0];
            timer_pkg::OFF_IMR:   interrupt_mask_reg_q <= hwdata[15:0];
            timer_pkg::OFF_AILR: begin
               interval_load_q[0] <= hwdata[15:0];
               if (!split)
                  interval_load_q[1] <= hwdata[31:16];
            end
            timer_pkg::OFF_BILR:  interval_load_q[1] <= hwdata[15:0];
            timer_pkg::OFF_AMATCH: begin
               match_reg_q[0] <= hwdata[15:0];
               if (!split)
                  match_reg_q[1] <= hwdata[31:16];
            end
            timer_pkg::OFF_BMATCH: match_reg_q[1]    <= hwdata[15:0];
            timer_pkg::OFF_APRE:   prescale_reg_q[0] <= hwdata[7:0];
            timer_pkg::OFF_BPRE:   prescale_reg_q[1] <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // control register, hardware clears enable at one-shot end or count match
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         timer_control_reg_q <= 16'h0000;
      else if (wr_ctl)
         timer_control_reg_q <= hwdata[15:0];
      else begin
         for (int n = 0; n < 2; n++) begin
            if ((timeout[n] && tmode[n] == timer_pkg::TM_ONESHOT) || cm_hit[n])
               timer_control_reg_q[n*timer_pkg::CTL_B_SHIFT
                                   + timer_pkg::CTL_EN] <= 1'b0;
         end
      end
   end

   // 16-bit counters and prescalers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int n = 0; n < 2; n++) begin
            cnt_q[n]  <= timer_pkg::CNT_RST;
            pcnt_q[n] <= timer_pkg::PRE_RST;
            cap_q[n]  <= timer_pkg::CNT_RST;
         end
      end else begin
         for (int n = 0; n < 2; n++) begin
            if (wr_ilr[n] && split) begin
               cnt_q[n]  <= hwdata[15:0];
               pcnt_q[n] <= prescale_reg_q[n];
            end else if (run[n]) begin
               unique case (tmode[n])
                  timer_pkg::TM_ONESHOT, timer_pkg::TM_PERIODIC: begin
                     if (pcnt_q[n] != 8'h00)
                        pcnt_q[n] <= 8'(pcnt_q[n] - 8'h01);
                     else if (cnt_q[n] == 16'h0000) begin
                        cnt_q[n]  <= interval_load_q[n];
                        pcnt_q[n] <= prescale_reg_q[n];
                     end else begin
                        cnt_q[n]  <= timer_pkg::dec16(cnt_q[n]);
                        pcnt_q[n] <= prescale_reg_q[n];
                     end
                  end
                  timer_pkg::TM_EDGE_COUNT: begin
                     if (cm_hit[n])
                        cnt_q[n] <= interval_load_q[n];
                     else if (edge_ok[n])
                        cnt_q[n] <= timer_pkg::dec16(cnt_q[n]);
                  end
                  timer_pkg::TM_EDGE_TIME, timer_pkg::TM_PWM: begin
                     // no prescaler here
                     if (cnt_q[n] == 16'h0000)
                        cnt_q[n] <= interval_load_q[n];
                     else
                        cnt_q[n] <= timer_pkg::dec16(cnt_q[n]);
                  end
                  timer_pkg::TM_IDLE: ;
               endcase
            end
            if (cap_hit[n])
               cap_q[n] <= cnt_q[n];
         end
      end
   end

   // pwm level and pin drive, inversion folded into the level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_q    <= 2'h0;
         pwm_oe_q <= 2'h0;
      end else begin
         for (int n = 0; n < 2; n++) begin
            logic inv;
            inv = timer_control_reg_q[n*timer_pkg::CTL_B_SHIFT
                                      + timer_pkg::CTL_PWML];
            pwm_oe_q[n] <= split && tmode[n] == timer_pkg::TM_PWM;
            if (!(split && tmode[n] == timer_pkg::TM_PWM) || !en[n])
               pwm_q[n] <= inv;
            else if (cnt_q[n] == interval_load_q[n])
               pwm_q[n] <= !inv;
            else if (cnt_q[n] == match_reg_q[n])
               pwm_q[n] <= inv;
         end
      end
   end

   // status flags, a set in the clearing cycle wins
   always_comb begin
      set_bits = 16'h0000;
      for (int n = 0; n < 2; n++) begin
         set_bits[n*timer_pkg::INT_B_SHIFT+timer_pkg::INT_TO] = timeout[n];
         set_bits[n*timer_pkg::INT_B_SHIFT+timer_pkg::INT_CM] = cm_hit[n];
         set_bits[n*timer_pkg::INT_B_SHIFT+timer_pkg::INT_CE] = cap_hit[n];
      end
      set_bits[timer_pkg::INT_RTC] = rtc_hit;
      ris_d = raw_status_reg_q;
      if (wr_icr)
         ris_d = ris_d & ~hwdata[15:0];
      ris_d = ris_d | set_bits;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         raw_status_reg_q <= 16'h0000;
         irq_q            <= 1'b0;
         trig_q           <= 2'h0;
      end else begin
         raw_status_reg_q <= ris_d;
         irq_q            <= |(ris_d & interrupt_mask_reg_q);
         for (int n = 0; n < 2; n++)
            trig_q[n] <= timeout[n] && timer_control_reg_q[
               n*timer_pkg::CTL_B_SHIFT+timer_pkg::CTL_OTE];
      end
   end

   // read data registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         rdata_q <= 32'h00000000;
      else if (hready && hsel && htrans[1] && !hwrite) begin
         unique case (haddr[11:0])
            timer_pkg::OFF_CFG:    rdata_q <= {29'h0, configuration_reg_q};
            timer_pkg::OFF_AMODE:  rdata_q <= {28'h0, timer_mode_reg_q[0]};
            timer_pkg::OFF_BMODE:  rdata_q <= {28'h0, timer_mode_reg_q[1]};
            timer_pkg::OFF_CTL:    rdata_q <= {16'h0, timer_control_reg_q};
            timer_pkg::OFF_IMR:    rdata_q <= {16'h0, interrupt_mask_reg_q};
            timer_pkg::OFF_RIS:    rdata_q <= {16'h0, raw_status_reg_q};
            timer_pkg::OFF_MIS:
               rdata_q <= {16'h0, raw_status_reg_q & interrupt_mask_reg_q};
            timer_pkg::OFF_AILR:
               rdata_q <= {interval_load_q[1], interval_load_q[0]};
            timer_pkg::OFF_BILR:   rdata_q <= {16'h0, interval_load_q[1]};
            timer_pkg::OFF_AMATCH: rdata_q <= rtc_match;
            timer_pkg::OFF_BMATCH: rdata_q <= {16'h0, match_reg_q[1]};
            timer_pkg::OFF_APRE:   rdata_q <= {24'h0, prescale_reg_q[0]};
            timer_pkg::OFF_BPRE:   rdata_q <= {24'h0, prescale_reg_q[1]};
            timer_pkg::OFF_AVAL: begin
               if (rtc_mode)
                  rdata_q <= rtc_q;
               else if (tmode[0] == timer_pkg::TM_EDGE_TIME)
                  rdata_q <= {16'h0, cap_q[0]};
               else
                  rdata_q <= {16'h0, cnt_q[0]};
            end
            timer_pkg::OFF_BVAL: begin
               if (rtc_mode)
                  rdata_q <= {16'h0, rtc_q[31:16]};
               else if (tmode[1] == timer_pkg::TM_EDGE_TIME)
                  rdata_q <= {16'h0, cap_q[1]};
               else
                  rdata_q <= {16'h0, cnt_q[1]};
            end
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end

   // outputs straight from flops
   assign hrdata               = rdata_q;
   assign timer_irq            = irq_q;
   assign trigger_a            = trig_q[0];
   assign trigger_b            = trig_q[1];
   assign capture_pin_zero_out = pwm_q[0];
   assign capture_pin_zero_oe  = pwm_oe_q[0];
   assign capture_pin_one_out  = pwm_q[1];
   assign capture_pin_one_oe   = pwm_oe_q[1];
endmodule // timer_rtc16
`default_nettype wire

// ===== timer_pkg.sv
`default_nettype none
package timer_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_CFG    = 12'h000;
   localparam logic [11:0] OFF_AMODE  = 12'h004;
   localparam logic [11:0] OFF_BMODE  = 12'h008;
   localparam logic [11:0] OFF_CTL    = 12'h00C;
   localparam logic [11:0] OFF_IMR    = 12'h018;
   localparam logic [11:0] OFF_RIS    = 12'h01C;
   localparam logic [11:0] OFF_MIS    = 12'h020;
   localparam logic [11:0] OFF_ICR    = 12'h024;
   localparam logic [11:0] OFF_AILR   = 12'h028;
   localparam logic [11:0] OFF_BILR   = 12'h02C;
   localparam logic [11:0] OFF_AMATCH = 12'h030;
   localparam logic [11:0] OFF_BMATCH = 12'h034;
   localparam logic [11:0] OFF_APRE   = 12'h038;
   localparam logic [11:0] OFF_BPRE   = 12'h03C;
   localparam logic [11:0] OFF_AVAL   = 12'h048;
   localparam logic [11:0] OFF_BVAL   = 12'h04C;
   // configuration values
   localparam logic [2:0] CFG_RTC   = 3'h1;
   localparam logic [2:0] CFG_SPLIT = 3'h4;
   // mode register fields
   localparam logic [1:0] MODE_ONESHOT  = 2'h1;
   localparam logic [1:0] MODE_PERIODIC = 2'h2;
   localparam logic [1:0] MODE_CAPTURE  = 2'h3;
   localparam int MODE_CMR_BIT = 2;
   localparam int MODE_AMS_BIT = 3;
   // control register fields, timer b sits one byte higher
   localparam int CTL_B_SHIFT = 8;
   localparam int CTL_EN      = 0;
   localparam int CTL_STALL   = 1;
   localparam int CTL_EVT     = 2;
   localparam int CTL_RTC_STALL_PERMIT   = 4;
   localparam int CTL_OTE     = 5;
   localparam int CTL_PWML    = 6;
   localparam logic [1:0] EVT_RISE = 2'h0;
   localparam logic [1:0] EVT_FALL = 2'h1;
   localparam logic [1:0] EVT_BOTH = 2'h3;
   // status bits, timer b sits one byte higher
   localparam int INT_B_SHIFT = 8;
   localparam int INT_TO      = 0;
   localparam int INT_CM      = 1;
   localparam int INT_CE      = 2;
   localparam int INT_RTC     = 3;
   // reset and load values
   localparam logic [15:0] CNT_RST   = 16'hFFFF;
   localparam logic [7:0]  PRE_RST   = 8'h00;
   localparam logic [31:0] RTC_START = 32'h00000001;
   localparam logic [31:0] RTC_ROLL  = 32'h00000000;
   // rtc input clock and tick rate, in hertz
   localparam int RTC_IN_HZ   = 32768;
   localparam int RTC_TICK_HZ = 1;
   localparam int RTC_DIV     = RTC_IN_HZ / RTC_TICK_HZ;
   localparam int CLK_HZ      = 10000000;

   typedef enum logic [2:0] {
      TM_IDLE, TM_ONESHOT, TM_PERIODIC, TM_EDGE_COUNT, TM_EDGE_TIME, TM_PWM
   } timer_mode_type;

   // mode register to operating mode
   function automatic timer_mode_type decode_mode(input logic [3:0] m);
      timer_mode_type r;
      r = TM_IDLE;
      unique case (m[1:0])
         MODE_ONESHOT: r = TM_ONESHOT;
         MODE_PERIODIC: begin
            if (m[MODE_AMS_BIT] && !m[MODE_CMR_BIT])
               r = TM_PWM;
            else
               r = TM_PERIODIC;
         end
         MODE_CAPTURE: r = m[MODE_CMR_BIT] ? TM_EDGE_TIME : TM_EDGE_COUNT;
         default: r = TM_IDLE;
      endcase
      return r;
   endfunction

   function automatic logic [15:0] dec16(input logic [15:0] v);
      return 16'(v - 16'h0001);
   endfunction
endpackage
`default_nettype wire

// ===== timer_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module timer_asserts (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        timer_irq,
   input wire logic        trigger_a,
   input wire logic        trigger_b,
   input wire logic        capture_pin_zero_oe,
   input wire logic        capture_pin_one_oe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // bus answers at once and always okay
   a_resp_okay: assert property (!hresp) else $error("hresp not okay");
   a_ready_high: assert property ($past(hresetn) |-> hreadyout)
      else $error("hreadyout low");
   a_rdata_hold: assert property (
      !(hready && hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
      else $error("hrdata moved");
   // quiet outputs while reset is held
   a_reset_quiet: assert property (disable iff (1'b0)
      !hresetn |-> !timer_irq && !trigger_a && !trigger_b && !hreadyout)
      else $error("output active in reset");
   a_pins_reset: assert property (disable iff (1'b0)
      !hresetn |-> !capture_pin_zero_oe && !capture_pin_one_oe)
      else $error("pin enabled in reset");
   // triggers are single pulses
   a_trig_a_pulse: assert property (trigger_a |=> !trigger_a [*2])
      else $error("trigger a not a pulse");
   a_trig_b_pulse: assert property (trigger_b |=> !trigger_b [*2])
      else $error("trigger b not a pulse");
   a_pwm_quiet: assert property (capture_pin_zero_oe |-> !trigger_a)
      else $error("time-out event in pwm");
   c_trig_a: cover property (trigger_a);
   c_trig_b: cover property (trigger_b);
   c_pwm: cover property (capture_pin_zero_oe);
   c_irq: cover property ($rose(timer_irq));
endmodule // timer_asserts
`default_nettype wire

// ===== pin_source.sv
`timescale 1ns/1ns
`default_nettype none
module pin_source (
   input  wire logic       hclk,
   input  wire logic [1:0] run,
   input  wire logic [8:0] half,
   output var  logic [1:0] pin
);
   logic [8:0] cnt_q [2];
   initial pin = 2'h0;
   initial cnt_q = '{9'h000, 9'h000};
   // square wave, each level held half clocks, still when not running
   always @(posedge hclk) begin
      for (int i = 0; i < 2; i++) begin
         if (run[i] && cnt_q[i] + 9'h001 >= half) begin
            cnt_q[i] <= 9'h000;
            pin[i] <= ~pin[i];
         end else if (run[i]) begin
            cnt_q[i] <= cnt_q[i] + 9'h001;
         end
      end
   end
endmodule // pin_source
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   typedef struct packed {logic [11:0] a; logic [31:0] e;} row_type;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic        trigger_a, trigger_b, o0, e0, o1, e1;
   logic [31:0] haddr, hwdata, hrdata, q, r;
   logic [1:0]  htrans, run, p;
   logic [2:0]  hsize;
   logic [8:0]  half;
   int          mismatches = 0, compares = 0, cyc = 0, last_b = 0;
   int          gap_b = 0, hi = 0, h;
   row_type     rows [7] = '{'{timer_pkg::OFF_CFG, 32'h0},
      '{timer_pkg::OFF_AMODE, 32'h0}, '{timer_pkg::OFF_AILR, 32'hFFFFFFFF},
      '{timer_pkg::OFF_AMATCH, 32'hFFFFFFFF}, '{timer_pkg::OFF_APRE, 32'h0},
      '{timer_pkg::OFF_RIS, 32'h0}, '{12'h100, 32'h0}};
   timer_rtc16 #(.RTC_DIV(4)) timer_rtc16_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timer_irq(irq),
      .trigger_a(trigger_a), .trigger_b(trigger_b),
      .capture_pin_zero_in(p[0]), .capture_pin_zero_out(o0),
      .capture_pin_zero_oe(e0), .capture_pin_one_in(p[1]),
      .capture_pin_one_out(o1), .capture_pin_one_oe(e1));
   pin_source pin_source_i (.hclk(hclk), .run(run), .half(half), .pin(p));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // cycle count, pwm high time, trigger spacing
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      hi <= hi + 32'(o0);
      if (trigger_b === 1'b1) begin
         gap_b <= cyc - last_b;
         last_b <= cyc;
      end
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic x(input logic w, input logic [11:0] a, input logic [31:0] d);
      haddr <= {20'h00000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic poll(input int b);
      q = '0;
      for (int k = 0; k < 4000 && q[b] !== 1'b1; k++) x(0, timer_pkg::OFF_RIS, 0);
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #3000000;
      mismatches++;
      print_verdict();
   end
   initial begin
      {hresetn, hwrite, htrans, haddr, hwdata, run} = '0;
      {hsel, hsize, half} = {1'b1, 3'h2, 9'd3};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[i]) begin
         x(0, rows[i].a, 0);
         chk("reset value", q, rows[i].e);
      end
      // split one-shot a with time-out unmasked
      x(1, timer_pkg::OFF_CFG, 4);
      x(1, timer_pkg::OFF_IMR, 1);
      x(1, timer_pkg::OFF_AMODE, 1);
      x(1, timer_pkg::OFF_AILR, 5);
      x(1, timer_pkg::OFF_CTL, 32'h21);
      poll(0);
      chk("timeout raw", 32'(q[0]), 1);
      chk("irq", 32'(irq), 1);
      x(0, timer_pkg::OFF_CTL, 0);
      chk("oneshot enable", 32'(q[0]), 0);
      x(0, timer_pkg::OFF_AVAL, 0);
      chk("oneshot reload", 32'(q[15:0]), 5);
      x(1, timer_pkg::OFF_ICR, 32'hFFFFFFFF);
      x(0, timer_pkg::OFF_RIS, 0);
      chk("cleared", q, 0);
      chk("irq off", 32'(irq), 0);
      // periodic b, prescale 1, load 3, trigger on
      x(1, timer_pkg::OFF_BMODE, 2);
      x(1, timer_pkg::OFF_BPRE, 1);
      x(1, timer_pkg::OFF_BILR, 3);
      x(1, timer_pkg::OFF_CTL, 32'h2100);
      repeat (40) @(posedge hclk);
      chk("period", 32'(gap_b), 8);
      x(1, timer_pkg::OFF_CTL, 32'h2300);
      x(0, timer_pkg::OFF_BVAL, 0);
      r = q;
      repeat (3) @(posedge hclk);
      x(0, timer_pkg::OFF_BVAL, 0);
      chk("stalled", q, r);
      // live reload of a running periodic a
      x(1, timer_pkg::OFF_AMODE, 2);
      x(1, timer_pkg::OFF_AILR, 32'h1000);
      x(1, timer_pkg::OFF_CTL, 1);
      x(1, timer_pkg::OFF_AILR, 32'h20);
      x(0, timer_pkg::OFF_AVAL, 0);
      chk("new load", 32'(q[15:0] <= 16'h0020 && q[15:0] > 16'h001C), 1);
      // edge count a on both edges, ten down to six
      x(1, timer_pkg::OFF_CTL, 0);
      x(1, timer_pkg::OFF_ICR, 32'hFFFFFFFF);
      x(1, timer_pkg::OFF_AMODE, 3);
      x(1, timer_pkg::OFF_AILR, 10);
      x(1, timer_pkg::OFF_AMATCH, 6);
      x(1, timer_pkg::OFF_IMR, 2);
      x(1, timer_pkg::OFF_CTL, 32'h0D);
      run <= 2'b01;
      poll(1);
      chk("match irq", 32'(irq), 1);
      x(0, timer_pkg::OFF_CTL, 0);
      chk("count stop", 32'(q[0]), 0);
      repeat (30) @(posedge hclk);
      x(0, timer_pkg::OFF_AVAL, 0);
      chk("count reload", 32'(q[15:0]), 10);
      // edge time b on rising edges, interrupt masked
      run <= 2'b00;
      x(1, timer_pkg::OFF_IMR, 0);
      x(1, timer_pkg::OFF_BMODE, 7);
      x(1, timer_pkg::OFF_CTL, 32'h100);
      run <= 2'b10;
      poll(10);
      run <= 2'b00;
      repeat (8) @(posedge hclk);
      chk("masked", 32'(irq), 0);
      x(0, timer_pkg::OFF_BVAL, 0);
      r = q;
      repeat (20) @(posedge hclk);
      x(0, timer_pkg::OFF_BVAL, 0);
      chk("capture held", q, r);
      // pwm a, load 20 match 10, plain then inverted
      x(1, timer_pkg::OFF_CTL, 0);
      x(1, timer_pkg::OFF_ICR, 32'hFFFFFFFF);
      x(1, timer_pkg::OFF_AMODE, 32'hA);
      x(1, timer_pkg::OFF_AILR, 20);
      x(1, timer_pkg::OFF_AMATCH, 10);
      for (int v = 0; v < 2; v++) begin
         x(1, timer_pkg::OFF_CTL, v ? 32'h41 : 32'h1);
         repeat (50) @(posedge hclk);
         h = hi;
         repeat (42) @(posedge hclk);
         chk("pwm high", 32'(hi - h), v ? 22 : 20);
      end
      chk("pwm enable", 32'({o1, e1, e0}), 1);
      x(0, timer_pkg::OFF_RIS, 0);
      chk("pwm flags", q, 0);
      // rtc with timer a stall set but permitted, match two
      x(1, timer_pkg::OFF_CTL, 0);
      x(1, timer_pkg::OFF_CFG, 1);
      x(1, timer_pkg::OFF_AMATCH, 2);
      x(1, timer_pkg::OFF_IMR, 8);
      half <= 9'd152;
      run <= 2'b01;
      x(1, timer_pkg::OFF_CTL, 32'h13);
      x(0, timer_pkg::OFF_AVAL, 0);
      chk("rtc start", q, 1);
      poll(3);
      chk("rtc irq", 32'(irq), 1);
      x(0, timer_pkg::OFF_AVAL, 0);
      chk("rtc roll", q, 0);
      x(1, timer_pkg::OFF_ICR, 8);
      x(0, timer_pkg::OFF_MIS, 0);
      chk("rtc clear", q, 0);
      print_verdict();
   end
endmodule // tb_top
bind timer_rtc16 timer_asserts timer_asserts_i (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .timer_irq(timer_irq), .trigger_a(trigger_a), .trigger_b(trigger_b),
   .capture_pin_zero_oe(capture_pin_zero_oe),
   .capture_pin_one_oe(capture_pin_one_oe));
`default_nettype wire
